// ### core/vr_bandwidth_gain_band_select.sv
`timescale 1ns/1ns
module vr_bandwidth_gain_band_select #(
  parameter int unsigned               ADDR_W        = 8,
  parameter logic [ADDR_W-1:0]         LATCH_ADDR    = '0,
  parameter bit                        OPTION_300K   = 1'b0,
  parameter logic [vr_ctrl_pkg::NUM_BANDS-1:0] EXTRA_FIT = '0
) (
  input  wire logic                             i_clk,
  input  wire logic                             i_reset_n,
  // Instrument bus pins
  input  wire logic [ADDR_W-1:0]                i_addr,
  input  wire logic [vr_ctrl_pkg::DATA_W-1:0]   i_data,
  input  wire logic                             i_data_valid,
  // First filter stage gets the whole bandwidth latch
  output logic [vr_ctrl_pkg::DATA_W-1:0]        o_first_filter_sel,
  // Second filter stage
  output logic [vr_ctrl_pkg::FILT_OUTS-1:0]     o_second_filter_n,
  output logic                                  o_wide_atten_path_n,
  output logic                                  o_xtal_switch_n,
  output logic                                  o_xtal_steer_n,
  output logic                                  o_xtal_path_en,
  output logic                                  o_filt_100k_n,
  output logic                                  o_filt_300k_n,
  output logic                                  o_filt_10k_n,
  output logic                                  o_filt_1k_n,
  output logic                                  o_bw_code_bad,
  // Gain steps
  output logic                                  o_gain_10db_a_n,
  output logic                                  o_gain_10db_b_n,
  output logic                                  o_gain_20db_n,
  output logic                                  o_gain_code_bad,
  // Open-collector band select and extra gain line
  output logic [vr_ctrl_pkg::NUM_BANDS-1:0]     o_band_sel_out,
  output logic [vr_ctrl_pkg::NUM_BANDS-1:0]     o_band_sel_oe,
  output logic                                  o_extra_gain_line_out,
  output logic                                  o_extra_gain_line_oe,
  // Written-since-reset flags
  output logic                                  o_bw_written,
  output logic                                  o_gain_band_written
);

  localparam int unsigned DW = vr_ctrl_pkg::DATA_W;
  localparam int unsigned NB = vr_ctrl_pkg::NUM_BANDS;
  localparam int unsigned NF = vr_ctrl_pkg::FILT_OUTS;

  logic          rst_meta_reg;
  logic          rst_n_reg;
  logic [ADDR_W-1:0] addr_meta_reg;
  logic [ADDR_W-1:0] addr_sync_reg;
  logic [DW-1:0] data_meta_reg;
  logic [DW-1:0] data_sync_reg;
  logic          valid_meta_reg;
  logic          valid_sync_reg;
  logic          valid_prev_reg;
  logic          write_hit;
  vr_ctrl_pkg::bus_state_e state_reg;
  vr_ctrl_pkg::bus_state_e state_next;
  logic [DW-1:0] load_data_reg;
  logic [DW-1:0] bw_latch_reg;
  logic [DW-1:0] gain_band_latch_reg;
  logic          bw_written_reg;
  logic          gain_band_written_reg;
  logic [3:0]    bw_index;
  logic [vr_ctrl_pkg::BAND_W-1:0] band_index;
  logic [2:0]    gain_code;
  logic [NF-1:0] filt_n;
  logic [NB-1:0] band_n;

  // Reset release through two flops
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // Bus pins pass two flops before use
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      addr_meta_reg  <= '0;
      addr_sync_reg  <= '0;
      data_meta_reg  <= '0;
      data_sync_reg  <= '0;
      valid_meta_reg <= 1'b0;
      valid_sync_reg <= 1'b0;
      valid_prev_reg <= 1'b0;
    end else begin
      addr_meta_reg  <= i_addr;
      addr_sync_reg  <= addr_meta_reg;
      data_meta_reg  <= i_data;
      data_sync_reg  <= data_meta_reg;
      valid_meta_reg <= i_data_valid;
      valid_sync_reg <= valid_meta_reg;
      valid_prev_reg <= valid_sync_reg;
    end
  end

  // Address decode qualified by the strobe's rising edge
  assign write_hit = valid_sync_reg && !valid_prev_reg && (addr_sync_reg == LATCH_ADDR);

  // Write sequencer: one load per strobe
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      vr_ctrl_pkg::ST_IDLE: if (write_hit) state_next = vr_ctrl_pkg::ST_LOAD;
      vr_ctrl_pkg::ST_LOAD: state_next = vr_ctrl_pkg::ST_HOLD;
      vr_ctrl_pkg::ST_HOLD: if (!valid_sync_reg) state_next = vr_ctrl_pkg::ST_IDLE;
      default:              state_next = vr_ctrl_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= vr_ctrl_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Capture data at the qualified edge
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      load_data_reg <= vr_ctrl_pkg::LATCH_RESET;
    end else if (state_reg == vr_ctrl_pkg::ST_IDLE && write_hit) begin
      load_data_reg <= data_sync_reg;
    end
  end

  // Bandwidth latch; bit 7 steers the write
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      bw_latch_reg   <= vr_ctrl_pkg::LATCH_RESET;
      bw_written_reg <= 1'b0;
    end else if (state_reg == vr_ctrl_pkg::ST_LOAD &&
                 load_data_reg[vr_ctrl_pkg::SEL_BIT] == vr_ctrl_pkg::SEL_BANDWIDTH) begin
      bw_latch_reg   <= load_data_reg;
      bw_written_reg <= 1'b1;
    end
  end

  // Gain and band latch
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      gain_band_latch_reg   <= vr_ctrl_pkg::LATCH_RESET;
      gain_band_written_reg <= 1'b0;
    end else if (state_reg == vr_ctrl_pkg::ST_LOAD &&
                 load_data_reg[vr_ctrl_pkg::SEL_BIT] == vr_ctrl_pkg::SEL_GAIN_BAND) begin
      gain_band_latch_reg   <= load_data_reg;
      gain_band_written_reg <= 1'b1;
    end
  end

  assign o_bw_written        = bw_written_reg;
  assign o_gain_band_written = gain_band_written_reg;
  assign o_first_filter_sel  = bw_latch_reg;

  // Field extraction
  assign bw_index   = {1'b0, bw_latch_reg[vr_ctrl_pkg::BW_MSB:vr_ctrl_pkg::BW_LSB]};
  assign band_index = gain_band_latch_reg[vr_ctrl_pkg::BAND_MSB:vr_ctrl_pkg::BAND_LSB];
  assign gain_code  = gain_band_latch_reg[vr_ctrl_pkg::GAIN_MSB:vr_ctrl_pkg::GAIN_LSB];

  // Second filter one-of-ten decoder
  vr_one_hot_decoder #(
    .IN_W (4),
    .OUTS (NF),
    .BASE (0)
  ) second_filter_decoder (
    .i_clk    (i_clk),
    .i_rst_n  (rst_n_reg),
    .i_enable (bw_written_reg),
    .i_index  (bw_index),
    .o_sel_n  (filt_n)
  );

  // Band decoder, band 1 on output 0
  vr_one_hot_decoder #(
    .IN_W (vr_ctrl_pkg::BAND_W),
    .OUTS (NB),
    .BASE (vr_ctrl_pkg::BAND_FIRST)
  ) band_one_hot_decoder (
    .i_clk    (i_clk),
    .i_rst_n  (rst_n_reg),
    .i_enable (gain_band_written_reg),
    .i_index  (band_index),
    .o_sel_n  (band_n)
  );

  assign o_second_filter_n = filt_n;

  // Filter path enables from decoder outputs
  assign o_wide_atten_path_n = filt_n[vr_ctrl_pkg::BW_3MHZ] & filt_n[vr_ctrl_pkg::BW_1MHZ];
  assign o_xtal_switch_n     = filt_n[vr_ctrl_pkg::BW_10HZ];
  assign o_xtal_steer_n      = filt_n[vr_ctrl_pkg::BW_100HZ];
  assign o_xtal_path_en      = !(filt_n[vr_ctrl_pkg::BW_10HZ] &
                                 filt_n[vr_ctrl_pkg::BW_100HZ]);
  assign o_filt_100k_n       = OPTION_300K ? 1'b1 : filt_n[vr_ctrl_pkg::BW_100KHZ];
  assign o_filt_300k_n       = OPTION_300K ? filt_n[vr_ctrl_pkg::BW_100KHZ] : 1'b1;
  assign o_filt_10k_n        = filt_n[vr_ctrl_pkg::BW_10KHZ];
  assign o_filt_1k_n         = filt_n[vr_ctrl_pkg::BW_1KHZ];

  // Flags codes outside the documented set
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_bw_code_bad   <= 1'b0;
      o_gain_code_bad <= 1'b0;
    end else begin
      o_bw_code_bad   <= bw_written_reg && (bw_index == 4'h0);
      o_gain_code_bad <= gain_band_written_reg &&
                         !(gain_code == vr_ctrl_pkg::GAIN_10DB ||
                           gain_code == vr_ctrl_pkg::GAIN_20DB ||
                           gain_code == vr_ctrl_pkg::GAIN_30DB ||
                           gain_code == vr_ctrl_pkg::GAIN_40DB);
    end
  end

  // Gain switches: latched one gives active-low enable
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_gain_10db_a_n <= 1'b1;
      o_gain_10db_b_n <= 1'b1;
      o_gain_20db_n   <= 1'b1;
    end else begin
      o_gain_10db_a_n <= !(gain_band_written_reg && gain_code[0]);
      o_gain_10db_b_n <= !(gain_band_written_reg && gain_code[1]);
      o_gain_20db_n   <= !(gain_band_written_reg && gain_code[2]);
    end
  end

  // Open-collector band lines: drive low only when selected
  assign o_band_sel_out        = '0;
  assign o_band_sel_oe         = ~band_n;
  assign o_extra_gain_line_out = 1'b0;
  assign o_extra_gain_line_oe  = |(~band_n & EXTRA_FIT & extra_range());

  // Mask of bands eligible for the extra gain connection
  function automatic logic [NB-1:0] extra_range();
    logic [NB-1:0] m;
    m = '0;
    for (int b = 0; b < NB; b++) begin
      m[b] = (b + vr_ctrl_pkg::BAND_FIRST >= vr_ctrl_pkg::EXTRA_FIRST) &&
             (b + vr_ctrl_pkg::BAND_FIRST <= vr_ctrl_pkg::EXTRA_LAST);
    end
    return m;
  endfunction : extra_range

endmodule : vr_bandwidth_gain_band_select

// ### core/vr_ctrl_pkg.sv
// Contract
// - Latch loads only on a valid-strobed write to its own decoded address.
// - Data bit 7 is an extra address bit choosing bandwidth or gain/band latch.
// - Bandwidth latch captures data and drives first and second filter selection.
// - Gain/band latch bits 0-2 each drive one gain-step switch output.
// - Gain/band latch bits 3-6 form the band number for the band decoder.
// - Band decoder pulls only the selected band output low, open-collector style.
// - Bands 4-10 may optionally also pull the shared extra-gain line low.
// - Second filter stage decodes bits 0-2 one-of-ten, chosen output low.
// - Bandwidths are 10 Hz to 1 MHz in decades plus 3 MHz only.
// - 3 MHz and 1 MHz codes both enable the shared unfiltered attenuator path.
// - 10 Hz and 100 Hz both enable crystal path via switches or steering.
// - Option variant uses a 300 kHz filter in the 100 kHz position.
// - Gain codes: 001=10, 100=20, 101=30, 111=40 dB; others unused.
// - Latched gain bit at one yields an active-low gain-step enable.
package vr_ctrl_pkg;

  localparam int unsigned DATA_W         = 8;
  localparam int unsigned SEL_BIT        = 7;
  localparam logic        SEL_BANDWIDTH  = 1'b0;
  localparam logic        SEL_GAIN_BAND  = 1'b1;

  // Gain/band latch field layout
  localparam int unsigned GAIN_LSB       = 0;
  localparam int unsigned GAIN_MSB       = 2;
  localparam int unsigned BAND_LSB       = 3;
  localparam int unsigned BAND_MSB       = 6;
  localparam int unsigned BAND_W         = 4;
  localparam int unsigned NUM_BANDS      = 11;
  localparam int unsigned BAND_FIRST     = 1;
  localparam int unsigned EXTRA_FIRST    = 4;
  localparam int unsigned EXTRA_LAST     = 10;

  // Gain step codes on bits 2,1,0
  localparam logic [2:0]  GAIN_10DB      = 3'h1;
  localparam logic [2:0]  GAIN_20DB      = 3'h4;
  localparam logic [2:0]  GAIN_30DB      = 3'h5;
  localparam logic [2:0]  GAIN_40DB      = 3'h7;

  // Bandwidth latch field and decimal decoder output codes
  localparam int unsigned BW_LSB         = 0;
  localparam int unsigned BW_MSB         = 2;
  localparam int unsigned FILT_OUTS      = 10;
  localparam logic [3:0]  BW_3MHZ        = 4'h1;
  localparam logic [3:0]  BW_100KHZ      = 4'h2;
  localparam logic [3:0]  BW_10KHZ       = 4'h3;
  localparam logic [3:0]  BW_1KHZ        = 4'h4;
  localparam logic [3:0]  BW_100HZ       = 4'h5;
  localparam logic [3:0]  BW_10HZ        = 4'h6;
  localparam logic [3:0]  BW_1MHZ        = 4'h7;

  localparam logic [7:0]  LATCH_RESET    = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_HOLD = 3'b100
  } bus_state_e;

endpackage : vr_ctrl_pkg

// ### core/vr_one_hot_decoder.sv
`timescale 1ns/1ns
// Registered one-of-N decoder, active-low outputs
module vr_one_hot_decoder #(
  parameter int unsigned IN_W  = 4,
  parameter int unsigned OUTS  = 10,
  parameter int unsigned BASE  = 0
) (
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  input  wire logic            i_enable,
  input  wire logic [IN_W-1:0] i_index,
  output logic      [OUTS-1:0] o_sel_n
);

  // One flop per output; all released while disabled
  generate
    for (genvar g = 0; g < OUTS; g++) begin : g_out
      localparam logic [IN_W-1:0] MATCH = IN_W'(g + BASE);
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_sel_n[g] <= 1'b1;
        end else begin
          o_sel_n[g] <= !(i_enable && (i_index == MATCH));
        end
      end
    end
  endgenerate

endmodule : vr_one_hot_decoder

// ### test/vr_select_sva.sv
`timescale 1ns/1ns
module vr_select_sva #(
  parameter int unsigned       ADDR_W     = 8,
  parameter logic [ADDR_W-1:0] LATCH_ADDR = '0,
  parameter logic [10:0]       EXTRA_FIT  = '0
) (
  input wire logic              i_clk,
  input wire logic              i_reset_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0]        i_data,
  input wire logic              i_data_valid,
  input wire logic [7:0]        o_first_filter_sel,
  input wire logic [9:0]        o_second_filter_n,
  input wire logic              o_wide_atten_path_n,
  input wire logic              o_xtal_path_en,
  input wire logic              o_gain_10db_a_n,
  input wire logic              o_gain_10db_b_n,
  input wire logic              o_gain_20db_n,
  input wire logic [10:0]       o_band_sel_out,
  input wire logic [10:0]       o_band_sel_oe,
  input wire logic              o_extra_gain_line_out,
  input wire logic              o_extra_gain_line_oe,
  input wire logic              o_gain_band_written
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Band number to pulled-low mask, bands 1 to 11
  function automatic logic [10:0] band_mask(input logic [3:0] b);
    return (b >= 4'h1 && b <= 4'hb) ? 11'h001 << (b - 4'h1) : 11'h000;
  endfunction : band_mask
  // Strobe edge to our address, bit 7 picks the latch
  sequence s_wr(logic sel);
    $rose(i_data_valid) && i_addr == LATCH_ADDR && i_data[7] == sel;
  endsequence
  property p_oc; o_band_sel_out == 11'h000 && !o_extra_gain_line_out; endproperty
  a_oc: assert property (p_oc) else $error("open drain line driven high");
  property p_onehot; $onehot0(o_band_sel_oe) && $onehot0(~o_second_filter_n); endproperty
  a_onehot: assert property (p_onehot) else $error("more than one select low");
  property p_bw; s_wr(1'b0) |-> ##7 o_first_filter_sel == $past(i_data, 7); endproperty
  a_bw: assert property (p_bw) else $error("bandwidth latch not loaded");
  property p_gain;
    s_wr(1'b1) |-> ##7 o_gain_band_written &&
      {o_gain_20db_n, o_gain_10db_b_n, o_gain_10db_a_n} == ~$past(i_data[2:0], 7);
  endproperty
  a_gain: assert property (p_gain) else $error("gain outputs wrong");
  property p_band; s_wr(1'b1) |-> ##7 o_band_sel_oe == band_mask($past(i_data[6:3], 7));
  endproperty
  a_band: assert property (p_band) else $error("band select wrong");
  property p_extra;
    s_wr(1'b1) |-> ##7
      o_extra_gain_line_oe == |(band_mask($past(i_data[6:3], 7)) & EXTRA_FIT & 11'h3f8);
  endproperty
  a_extra: assert property (p_extra) else $error("extra gain line wrong");
  property p_hold; s_wr(1'b1) |-> ##1 $stable(o_first_filter_sel) [*8]; endproperty
  a_hold: assert property (p_hold) else $error("bandwidth latch disturbed");
  property p_miss;
    $rose(i_data_valid) && i_addr != LATCH_ADDR |->
      ##1 $stable({o_first_filter_sel, o_band_sel_oe}) [*8];
  endproperty
  a_miss: assert property (p_miss) else $error("latch loaded from other address");
  property p_wide;
    1'b1 |=> o_wide_atten_path_n == !($past(o_first_filter_sel[2:0]) inside {3'h1, 3'h7});
  endproperty
  a_wide: assert property (p_wide) else $error("attenuator path wrong");
  property p_xtal;
    1'b1 |=> o_xtal_path_en == ($past(o_first_filter_sel[2:0]) inside {3'h5, 3'h6});
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal path wrong");
  c_bw: cover property (s_wr(1'b0));
  c_gain: cover property (s_wr(1'b1));
  c_extra: cover property (o_extra_gain_line_oe);
endmodule : vr_select_sva

// ### test/vr_host_model.sv
`timescale 1ns/1ns
module vr_host_model (
  input  wire logic       i_clk,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_data,
  output logic            o_data_valid
);
  // Bus idle at start
  initial begin
    o_addr = 8'hff;
    o_data = 8'hff;
    o_data_valid = 1'b0;
  end
  // One strobed write, entered at a falling edge; data is not limited to listed codes
  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    o_addr = addr;
    o_data = data;
    repeat (2) @(negedge i_clk);
    o_data_valid = 1'b1;
    repeat (4) @(negedge i_clk);
    o_data_valid = 1'b0;
    o_addr = ~addr; // Released bus shows no stale value
    o_data = ~data;
    repeat (3) @(negedge i_clk);
  endtask : write
endmodule : vr_host_model

// ### test/vr_bandwidth_gain_band_select_tb_top.sv
`timescale 1ns/1ns
module vr_bandwidth_gain_band_select_tb_top;
  localparam logic [7:0]  ADDR = 8'h5a;
  localparam logic [10:0] FIT  = 11'h609;
  localparam logic [2:0]  GC [4] = '{3'h1, 3'h4, 3'h5, 3'h7};
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [7:0]  addr, data, first_sel;
  logic        valid, wide_n, sw_n, steer_n, xen, f100_n, f300_n, f10_n, f1_n, bw_bad;
  logic        ga_n, gb_n, g20_n, gbad, eg_out, eg_oe, bw_wr, gb_wr;
  logic [9:0]  second_n;
  logic [10:0] band_out, band_oe;
  int          miscompares = 0;
  int          n_tests = 0;
  always #4 i_clk = ~i_clk;
  vr_host_model u_vr_host_model (.i_clk(i_clk), .o_addr(addr), .o_data(data),
    .o_data_valid(valid));
  vr_bandwidth_gain_band_select #(.LATCH_ADDR(ADDR), .EXTRA_FIT(FIT))
    u_vr_bandwidth_gain_band_select (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(addr),
    .i_data(data), .i_data_valid(valid), .o_first_filter_sel(first_sel),
    .o_second_filter_n(second_n), .o_wide_atten_path_n(wide_n), .o_xtal_switch_n(sw_n),
    .o_xtal_steer_n(steer_n), .o_xtal_path_en(xen), .o_filt_100k_n(f100_n),
    .o_filt_300k_n(f300_n), .o_filt_10k_n(f10_n), .o_filt_1k_n(f1_n), .o_bw_code_bad(bw_bad),
    .o_gain_10db_a_n(ga_n), .o_gain_10db_b_n(gb_n), .o_gain_20db_n(g20_n),
    .o_gain_code_bad(gbad), .o_band_sel_out(band_out), .o_band_sel_oe(band_oe),
    .o_extra_gain_line_out(eg_out), .o_extra_gain_line_oe(eg_oe), .o_bw_written(bw_wr),
    .o_gain_band_written(gb_wr));
  // Compare and count
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask : check
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // Every bandwidth code through both filter stages
  task automatic t_bw();
    logic [2:0] c;
    logic [9:0] f;
    for (int i = 1; i < 8; i++) begin
      c = i[2:0];
      f = ~(10'h001 << c);
      u_vr_host_model.write(ADDR, {5'h00, c});
      check("first", 16'(first_sel), 16'(c));
      check("second", 16'(second_n), 16'(f));
      check("wide", 16'(wide_n), 16'(!(c == 3'h1 || c == 3'h7)));
      check("xtal", 16'({xen, sw_n, steer_n}),
        16'({c inside {3'h5, 3'h6}, c != 3'h6, c != 3'h5}));
      check("filt", 16'({f100_n, f300_n, f10_n, f1_n, bw_bad}),
        16'({c != 3'h2, 1'b1, c != 3'h3, c != 3'h4, 1'b0}));
    end
  endtask : t_bw
  // Band numbers 0 to 12, every one in range and one either side, with the gain codes in turn
  task automatic t_gain();
    logic [2:0]  g;
    logic [10:0] m;
    for (int i = 0; i < 13; i++) begin
      g = GC[i % 4];
      m = (i >= 1 && i <= 11) ? 11'h001 << (i - 1) : 11'h000;
      u_vr_host_model.write(ADDR, {1'b1, i[3:0], g});
      check("gain", 16'({ga_n, gb_n, g20_n, gbad}),
        16'({~g[0], ~g[1], ~g[2], 1'b0}));
      check("band", 16'(band_oe), 16'(m));
      check("extra", 16'({eg_oe, eg_out, band_out}),
        16'({|(m & FIT & 11'h3f8), 12'h000}));
      check("hold", 16'(first_sel), 16'h0007);
    end
  endtask : t_gain
  // Writes elsewhere are ignored, then a hit right after
  task automatic t_miss();
    u_vr_host_model.write(ADDR ^ 8'h01, 8'h03);
    check("miss bw", 16'(first_sel), 16'h0007);
    u_vr_host_model.write(ADDR ^ 8'h10, 8'h89);
    check("miss band", 16'(band_oe), 16'h0000);
    u_vr_host_model.write(ADDR, 8'h02);
    check("hit", 16'({first_sel, f100_n, band_oe[0]}), 16'h0008);
  endtask : t_miss
  initial begin
    repeat (4) @(negedge i_clk);
    i_reset_n = 1'b1;
    repeat (3) @(negedge i_clk);
    check("reset", 16'({bw_wr, gb_wr, band_oe}), 16'h0000);
    check("reset sel", 16'(second_n), 16'h03ff);
    t_bw();
    t_gain();
    check("written", 16'({bw_wr, gb_wr}), 16'h0003);
    t_miss();
    finish_test();
  end
endmodule : vr_bandwidth_gain_band_select_tb_top
bind vr_bandwidth_gain_band_select vr_select_sva #(.ADDR_W(ADDR_W), .LATCH_ADDR(LATCH_ADDR),
  .EXTRA_FIT(EXTRA_FIT)) u_vr_select_sva (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_addr(i_addr), .i_data(i_data), .i_data_valid(i_data_valid),
  .o_first_filter_sel(o_first_filter_sel), .o_second_filter_n(o_second_filter_n),
  .o_wide_atten_path_n(o_wide_atten_path_n), .o_xtal_path_en(o_xtal_path_en),
  .o_gain_10db_a_n(o_gain_10db_a_n), .o_gain_10db_b_n(o_gain_10db_b_n),
  .o_gain_20db_n(o_gain_20db_n), .o_band_sel_out(o_band_sel_out),
  .o_band_sel_oe(o_band_sel_oe), .o_extra_gain_line_out(o_extra_gain_line_out),
  .o_extra_gain_line_oe(o_extra_gain_line_oe), .o_gain_band_written(o_gain_band_written));
